// ==== adc_ctrl.sv ====
// converter control, status and result registers behind an ahb-lite slave
// assumes one slave on the bus, single word transfers, comparator from the core
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module adc_ctrl (
    input wire logic hclk, // system clock, 20 mhz
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic cmp_in, // core comparator, input above trial
    output adc_pkg::core_ctrl_s core_ctrl, // controls to analog core
    output logic done_flag // completion flag level
);

    typedef struct packed {
        adc_pkg::conv_state_e state;
        logic justify;
        logic ref_ext;
        logic [1:0] chan;
        logic enable;
        logic [7:0] res_hi;
        logic [7:0] res_lo;
        logic flag;
        logic [2:0] clksel;
        logic [adc_pkg::RES_W-1:0] sar;
        logic [adc_pkg::RES_W-1:0] mask;
        logic [1:0] abort_cnt;
        logic wr_pend;
        logic rd_pend;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic cmp_s1;
        logic cmp_s2;
    } ctrl_state_s;

    ctrl_state_s st_q;
    ctrl_state_s st_d;
    logic tick;
    logic tick_clear;
    logic addr_ok;
    logic [7:0] wbyte;
    logic [adc_pkg::RES_W-1:0] final_res;
    logic wr_ctrl;
    logic busy;

    // conversion clock divider, restarted at each start and abort
    tad_tick_gen u_tad (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(tick_clear),
        .clk_sel(st_q.clksel),
        .tick(tick)
    );

    // read data for an offset, from current state
    function automatic logic [7:0] read_byte(input ctrl_state_s s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == adc_pkg::OFS_CTRL) begin
            v[adc_pkg::BIT_JUSTIFY] = s.justify;
            v[adc_pkg::BIT_REF] = s.ref_ext;
            v[adc_pkg::BIT_CHAN_HI:adc_pkg::BIT_CHAN_LO] = s.chan;
            v[adc_pkg::BIT_GO] = (s.state == adc_pkg::ST_CONV);
            v[adc_pkg::BIT_EN] = s.enable;
        end else if (a == adc_pkg::OFS_RES_HI) begin
            v = s.res_hi;
        end else if (a == adc_pkg::OFS_RES_LO) begin
            v = s.res_lo;
        end else if (a == adc_pkg::OFS_FLAG) begin
            v[adc_pkg::BIT_FLAG] = s.flag;
        end else if (a == adc_pkg::OFS_CLKSEL) begin
            v[2:0] = s.clksel;
        end
        return v;
    endfunction

    // software view of result bytes depends on justification
    function automatic logic [7:0] res_mask(input logic right, input logic high);
        logic [7:0] m;
        if (right) begin
            m = high ? adc_pkg::MASK_RIGHT_HI : adc_pkg::MASK_RIGHT_LO;
        end else begin
            m = high ? adc_pkg::MASK_LEFT_HI : adc_pkg::MASK_LEFT_LO;
        end
        return m;
    endfunction

    // static outputs and helpers
    assign hrdata = st_q.rdata;
    assign hreadyout = !st_q.rd_pend;
    assign hresp = 1'b0;
    assign done_flag = st_q.flag;
    assign busy = (st_q.state == adc_pkg::ST_CONV);
    assign wbyte = hwdata[7:0];
    assign addr_ok = hsel && htrans[1] && hready;
    assign wr_ctrl = st_q.wr_pend && (st_q.addr == adc_pkg::OFS_CTRL);

    // analog core controls; core unpowered while disabled
    always_comb begin
        core_ctrl.power_on = st_q.enable;
        core_ctrl.ref_ext = st_q.ref_ext;
        core_ctrl.chan = st_q.chan;
        core_ctrl.sampling = st_q.enable && (st_q.state == adc_pkg::ST_IDLE);
        core_ctrl.trial = st_q.sar;
    end

    // bit decision of the current trial; a low comparator drops the bit
    always_comb begin
        final_res = cmp_keep(st_q.cmp_s2) ? st_q.sar : (st_q.sar & ~st_q.mask);
    end

    function automatic logic cmp_keep(input logic c);
        return c;
    endfunction

    // divider restart on a start or an abort request
    always_comb begin
        tick_clear = 1'b0;
        if (wr_ctrl) begin
            if (st_q.state == adc_pkg::ST_IDLE && wbyte[adc_pkg::BIT_GO]
                && wbyte[adc_pkg::BIT_EN]) begin
                tick_clear = 1'b1;
            end else if (busy && !(wbyte[adc_pkg::BIT_GO] && wbyte[adc_pkg::BIT_EN])) begin
                tick_clear = 1'b1;
            end
        end
    end

    // next state: bus, registers and successive approximation
    always_comb begin
        st_d = st_q;

        // comparator crosses from the analog side: two flops first
        st_d.cmp_s1 = cmp_in;
        st_d.cmp_s2 = st_q.cmp_s1;

        // bus address phase; reads wait one cycle so a prior write is seen
        st_d.wr_pend = 1'b0;
        st_d.rd_pend = 1'b0;
        if (st_q.rd_pend) begin
            st_d.rdata = {24'h000000, read_byte(st_q, st_q.addr)};
        end
        if (addr_ok) begin
            st_d.addr = haddr[7:0];
            st_d.wr_pend = hwrite;
            st_d.rd_pend = !hwrite;
            if (haddr[31:8] != 24'h000000) begin
                st_d.addr = 8'hff; // unmapped: reads zero, writes dropped
            end
        end

        // conversion sequencer, one step per conversion clock tick
        case (st_q.state)
            adc_pkg::ST_IDLE: begin
                st_d.mask = '0;
            end
            adc_pkg::ST_CONV: begin
                if (tick) begin
                    if (st_q.mask == '0) begin
                        // first period is overhead, then msb trial
                        st_d.mask = adc_pkg::TRIAL_MSB;
                        st_d.sar = adc_pkg::TRIAL_MSB;
                    end else if (st_q.mask == adc_pkg::TRIAL_LSB) begin
                        // eleventh period ends: load, flag, clear go
                        st_d.state = adc_pkg::ST_IDLE;
                        st_d.sar = final_res;
                        st_d.flag = 1'b1;
                        st_d.mask = '0;
                        if (st_q.justify) begin
                            st_d.res_hi = {6'h00, final_res[9:8]};
                            st_d.res_lo = final_res[7:0];
                        end else begin
                            st_d.res_hi = final_res[9:2];
                            st_d.res_lo = {final_res[1:0], 6'h00};
                        end
                    end else begin
                        // decide this bit and try the next lower one
                        st_d.mask = st_q.mask >> 1;
                        st_d.sar = final_res | (st_q.mask >> 1);
                    end
                end
            end
            adc_pkg::ST_ABORT: begin
                // restart delay before acquisition resumes
                if (tick) begin
                    st_d.abort_cnt = st_q.abort_cnt + 2'h1;
                    if (st_q.abort_cnt + 2'h1 == adc_pkg::ABORT_TADS) begin
                        st_d.state = adc_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                st_d.state = adc_pkg::ST_IDLE;
            end
        endcase

        // bus write data phase; software wins over a same-edge completion except at the flag register while the flag is clear
        if (st_q.wr_pend) begin
            if (st_q.addr == adc_pkg::OFS_CTRL) begin
                st_d.justify = wbyte[adc_pkg::BIT_JUSTIFY];
                st_d.ref_ext = wbyte[adc_pkg::BIT_REF];
                st_d.chan = wbyte[adc_pkg::BIT_CHAN_HI:adc_pkg::BIT_CHAN_LO];
                st_d.enable = wbyte[adc_pkg::BIT_EN];
                if (st_q.state == adc_pkg::ST_IDLE) begin
                    if (wbyte[adc_pkg::BIT_GO] && wbyte[adc_pkg::BIT_EN]) begin
                        // start: trials begin after the overhead period
                        st_d.state = adc_pkg::ST_CONV;
                        st_d.mask = '0;
                        st_d.sar = '0;
                    end
                end else if (busy) begin
                    if (!(wbyte[adc_pkg::BIT_GO] && wbyte[adc_pkg::BIT_EN])) begin
                        // go or enable cleared: drop partial result
                        st_d.state = adc_pkg::ST_ABORT;
                        st_d.abort_cnt = '0;
                        st_d.mask = '0;
                        st_d.flag = st_q.flag;
                        st_d.res_hi = st_q.res_hi;
                        st_d.res_lo = st_q.res_lo;
                        st_d.sar = st_q.sar;
                    end
                end
            end else if (st_q.addr == adc_pkg::OFS_RES_HI) begin
                st_d.res_hi = wbyte & res_mask(st_q.justify, 1'b1);
            end else if (st_q.addr == adc_pkg::OFS_RES_LO) begin
                st_d.res_lo = wbyte & res_mask(st_q.justify, 1'b0);
            end else if (st_q.addr == adc_pkg::OFS_FLAG) begin
                // writing zero clears; a completion on the same edge wins unless the flag was already set
                if (!wbyte[adc_pkg::BIT_FLAG] && st_d.flag == st_q.flag) begin
                    st_d.flag = 1'b0;
                end
            end else if (st_q.addr == adc_pkg::OFS_CLKSEL) begin
                st_d.clksel = wbyte[2:0];
            end
        end
    end

    // single register for all state except the divider count, which u_tad holds
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
            st_q.state <= adc_pkg::ST_IDLE;
            st_q.justify <= adc_pkg::CTRL_RESET[adc_pkg::BIT_JUSTIFY];
            st_q.ref_ext <= adc_pkg::CTRL_RESET[adc_pkg::BIT_REF];
            st_q.enable <= adc_pkg::CTRL_RESET[adc_pkg::BIT_EN];
            st_q.res_hi <= adc_pkg::RES_RESET;
            st_q.res_lo <= adc_pkg::RES_RESET;
            st_q.clksel <= adc_pkg::CLKSEL_RESET;
        end else begin
            st_q <= st_d;
        end
    end

endmodule

// ==== adc_pkg.sv ====
// package for the converter control and result register block
// assumes an ahb-lite slave port at 32 bits and a comparator-based analog core
package adc_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RES_HI = 8'h04;
    localparam logic [7:0] OFS_RES_LO = 8'h08;
    localparam logic [7:0] OFS_FLAG = 8'h0c;
    localparam logic [7:0] OFS_CLKSEL = 8'h10;

    // control and flag register field positions
    localparam int BIT_JUSTIFY = 7;
    localparam int BIT_REF = 6;
    localparam int BIT_CHAN_HI = 3;
    localparam int BIT_CHAN_LO = 2;
    localparam int BIT_GO = 1;
    localparam int BIT_EN = 0;
    localparam int BIT_FLAG = 0;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RES_RESET = 8'h00;
    localparam logic [2:0] CLKSEL_RESET = 3'h0;

    // result layout
    localparam int RES_W = 10;
    localparam logic [9:0] TRIAL_MSB = 10'h200;
    localparam logic [9:0] TRIAL_LSB = 10'h001;
    localparam logic [7:0] MASK_RIGHT_HI = 8'h03;
    localparam logic [7:0] MASK_RIGHT_LO = 8'hff;
    localparam logic [7:0] MASK_LEFT_HI = 8'hff;
    localparam logic [7:0] MASK_LEFT_LO = 8'hc0;

    // conversion clock: code n divides hclk by 2 << n, top code 5
    localparam int TAD_CNT_W = 7;
    localparam logic [2:0] CLKSEL_MAX = 3'h5;
    localparam logic [TAD_CNT_W-1:0] TAD_BASE = 7'h02;
    localparam logic [TAD_CNT_W-1:0] TAD_ONE = 7'h01;
    localparam logic [1:0] ABORT_TADS = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONV,
        ST_ABORT
    } conv_state_e;

    // controls toward the analog core
    typedef struct packed {
        logic power_on;
        logic ref_ext;
        logic [1:0] chan;
        logic sampling;
        logic [RES_W-1:0] trial;
    } core_ctrl_s;

endpackage

// ==== tad_tick_gen.sv ====
// conversion clock divider producing a one-cycle tick per period
// assumes hclk domain only; clear restarts the period from zero
`timescale 1ns/1ps
module tad_tick_gen (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic clear, // restart the period
    input wire logic [2:0] clk_sel, // divide code
    output logic tick // one cycle at period end
);

    typedef struct packed {
        logic [adc_pkg::TAD_CNT_W-1:0] cnt;
    } tick_state_s;

    tick_state_s st_q;
    tick_state_s st_d;
    logic [2:0] sel_c;
    logic [adc_pkg::TAD_CNT_W-1:0] limit;

    // codes above the top divide saturate rather than wrap
    always_comb begin
        sel_c = (clk_sel > adc_pkg::CLKSEL_MAX) ? adc_pkg::CLKSEL_MAX : clk_sel;
        limit = (adc_pkg::TAD_BASE << sel_c) - adc_pkg::TAD_ONE;
        tick = (st_q.cnt == limit) && !clear;
        st_d = st_q;
        if (clear || tick) begin
            st_d.cnt = '0;
        end else begin
            st_d.cnt = st_q.cnt + adc_pkg::TAD_ONE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule

// ==== adc_ctrl_chk.sv ====
// checker for the converter control block, watching its ports only
// assumes one hclk domain, reset hresetn, attached by bind below
`timescale 1ns/1ps
module adc_ctrl_chk (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    input wire logic [31:0] hrdata, // read data
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic cmp_in, // comparator
    input wire adc_pkg::core_ctrl_s core_ctrl, // core controls
    input wire logic done_flag // completion flag
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic wr0;
    logic rd_req;
    // address phases of interest
    assign wr0 = hsel && htrans[1] && hready && hwrite && haddr == 32'h0;
    assign rd_req = hsel && htrans[1] && hready && !hwrite;
    a_ctrl_fields: assert property (wr0 ##1 1'b1 |=>
        core_ctrl.power_on == $past(hwdata[0]) && core_ctrl.ref_ext == $past(hwdata[6])
        && core_ctrl.chan == $past(hwdata[3:2]))
        else $error("control fields differ from written value");
    a_off_idle: assert property (!core_ctrl.power_on |-> !core_ctrl.sampling)
        else $error("sampling while converter is off");
    a_done_idle: assert property ($rose(done_flag) |-> core_ctrl.sampling)
        else $error("flag set without return to idle");
    a_done_after_run: assert property ($rose(done_flag) |-> !$past(core_ctrl.sampling))
        else $error("flag set with no conversion running");
    a_start_busy: assert property (
        wr0 ##1 (hwdata[1:0] == 2'h3 && core_ctrl.sampling) |=> !core_ctrl.sampling [*8])
        else $error("start did not leave idle");
    a_abort_hold: assert property (
        wr0 ##1 (!hwdata[1] && !core_ctrl.sampling && core_ctrl.power_on)
        |=> (!core_ctrl.sampling && !$rose(done_flag)) [*3])
        else $error("abort restarted early or set the flag");
    a_ctrl_readback: assert property (
        hreadyout && !$past(hreadyout) && $past(haddr, 2) == 32'h0
        |-> hrdata[31:8] == 24'h0 && hrdata[5:4] == 2'h0
        && hrdata[0] == core_ctrl.power_on && hrdata[3:2] == core_ctrl.chan)
        else $error("control readback wrong");
    // one wait cycle per read keeps timing known to software
    a_read_wait: assert property (rd_req |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
endmodule
bind adc_ctrl adc_ctrl_chk adc_ctrl_chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cmp_in(cmp_in), .core_ctrl(core_ctrl), .done_flag(done_flag));

// ==== adc_core_model.sv ====
// analog core stand-in: four input codes and a comparator
// assumes core_ctrl from adc_ctrl; input codes set by the bench
`timescale 1ns/1ps
module adc_core_model (
    input wire logic hclk, // system clock
    input wire adc_pkg::core_ctrl_s core_ctrl, // controls from block
    input wire logic [3:0][9:0] level, // input codes against supply
    output logic cmp_in // comparator level
);
    logic [9:0] code;
    logic junk_q = 1'b0;
    // external reference is twice the supply here, so codes halve
    assign code = core_ctrl.ref_ext ? level[core_ctrl.chan] >> 1 : level[core_ctrl.chan];
    // an unpowered comparator means nothing, so it toggles instead of holding
    always @(posedge hclk) begin
        junk_q <= !junk_q;
    end
    assign cmp_in = core_ctrl.power_on ? (code >= core_ctrl.trial) : junk_q;
endmodule

// ==== tb.sv ====
// self-checking bench for adc_ctrl over ahb-lite with a core model
// assumes hready is the slave's own hreadyout, one slave on the bus
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_fail++; \
    $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module tb;
    logic hclk, hresetn, hsel, hwrite, cmp_in, done_flag, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0][9:0] level;
    logic [9:0] res;
    logic [7:0] ctl;
    adc_pkg::core_ctrl_s core_ctrl;
    int n_fail = 0, tests_run = 0, cyc = 0, t0;
    adc_ctrl adc_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cmp_in(cmp_in), .core_ctrl(core_ctrl), .done_flag(done_flag));
    adc_core_model adc_core_model_i (.hclk(hclk), .core_ctrl(core_ctrl), .level(level),
        .cmp_in(cmp_in));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task give_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    // one single transfer; address held until hready, then data until hready
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input string n, input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(n, e, rd)
    endtask
    // full conversion with polling; clock select 1 gives a 4-cycle period
    task automatic conv(input logic [1:0] ch, input logic j, input logic r);
        ctl = {j, r, 2'h0, ch, 2'h0};
        res = r ? level[ch] >> 1 : level[ch];
        xfer(1'b1, 32'h0, {24'h0, ctl});
        xfer(1'b1, 32'h0, {24'h0, ctl | 8'h01});
        repeat (20) @(posedge hclk);
        xfer(1'b1, 32'h0, {24'h0, ctl | 8'h03});
        @(negedge hclk);
        t0 = cyc;
        rdchk("go busy", 32'h0, {24'h0, ctl | 8'h03});
        while (done_flag !== 1'b1) @(negedge hclk);
        `CHK("conv cycles", 44, cyc - t0)
        `CHK("trial", res, core_ctrl.trial)
        rdchk("go done", 32'h0, {24'h0, ctl | 8'h01});
        rdchk("res hi", 32'h4, {24'h0, j ? {6'h0, res[9:8]} : res[9:2]});
        rdchk("res lo", 32'h8, {24'h0, j ? res[7:0] : {res[1:0], 6'h0}});
        rdchk("flag set", 32'hc, 32'h1);
        xfer(1'b1, 32'hc, 32'h0);
        rdchk("flag clr", 32'hc, 32'h0);
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        level = {10'h15a, 10'h2a5, 10'h000, 10'h3ff};
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, unmapped places read zero and drop writes
        for (int k = 0; k < 7; k++) rdchk("reset", k == 6 ? 32'h100 : k * 4, 32'h0);
        xfer(1'b1, 32'h14, 32'hff);
        rdchk("unmapped", 32'h14, 32'h0);
        xfer(1'b1, 32'h0, 32'hfe);
        rdchk("ctrl mask", 32'h0, 32'hcc);
        xfer(1'b1, 32'h10, 32'h1);
        conv(2'h0, 1'b1, 1'b0);
        conv(2'h1, 1'b0, 1'b0);
        conv(2'h2, 1'b0, 1'b1);
        conv(2'h3, 1'b1, 1'b1);
        // abort right after start keeps the old result
        level[3] <= 10'h3c3;
        xfer(1'b1, 32'h0, {24'h0, ctl | 8'h03});
        xfer(1'b1, 32'h0, {24'h0, ctl | 8'h01});
        repeat (60) @(negedge hclk);
        rdchk("abort lo", 32'h8, {24'h0, res[7:0]});
        rdchk("abort flag", 32'hc, 32'h0);
        `CHK("abort idle", 1'b1, core_ctrl.sampling)
        xfer(1'b1, 32'h4, 32'hff);
        rdchk("masked hi", 32'h4, 32'h3);
        xfer(1'b1, 32'h0, 32'h0);
        @(negedge hclk);
        `CHK("power off", 1'b0, core_ctrl.power_on)
        give_verdict();
    end
endmodule
